//--- cmsd_pkg.sv
// constants, types and behaviour list for the control mode strap decoder
// Behaviour
// - primary select strap high gives pin-controlled mode with the serial port idle
// - primary floating, secondary floating or high: range strap picks pin or extended mode
// - pin mode: range strap high gives normal full scale, low gives reduced
// - extended mode when primary low, or primary floating and range floats; secondary floating or high
// - pin mode: swing strap high gives normal output swing, low gives reduced
// - pin mode: edge strap high launches data on positive edge, low on negative
// - pin mode: floating edge strap gives double-rate output clock, edge choice ignored
// - pin mode: calibration delay strap low gives short delay, high gives long
// - pin mode: floating calibration delay strap gives short delay plus dual-edge sampling
// - extended mode: swing, edge, delay pins become serial clock, data, chip select
// - dual-edge sampling feeds one input pair to both converters, other pair off
// - double-rate clocking: one word per output clock edge, clock at quarter rate
package cmsd_pkg;

  // ==========================================================
  // strap layout
  localparam int STRAP_N = 6;
  localparam int ST_PRIM = 0;
  localparam int ST_SEC = 1;
  localparam int ST_RANGE = 2;
  localparam int ST_SWING = 3;
  localparam int ST_EDGE = 4;
  localparam int ST_CALIBRATION_DELAY_SELECT = 5;
  // consecutive equal samples before a strap level is accepted
  localparam logic [1:0] STABLE_LAST = 2'h3;

  typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_FLOAT} cmsd_level_t;

  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [31:0] CFG_RST = 32'h0000_0043;
  localparam int CFG_SWING = 0;
  localparam int CFG_EDGE = 1;
  localparam int CFG_DDR = 2;
  localparam int CFG_CAL = 3;
  localparam int CFG_DES = 4;
  localparam int CFG_DESQ = 5;
  localparam int CFG_FSR = 6;
  localparam int CFG_W = 7;
  localparam int STAT_EXT = 12;
  localparam int STAT_DES = 13;
  localparam int STAT_DDR = 14;

  // ==========================================================
  // output clock phase counter
  localparam logic [1:0] PH_RST = 2'h0;
  localparam logic [1:0] PH_STEP = 2'h1;

  typedef struct packed {
    cmsd_level_t [STRAP_N-1:0] cand;
    logic [STRAP_N-1:0][1:0] cnt;
    cmsd_level_t [STRAP_N-1:0] stable;
  } cmsd_sense_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [31:0] rdata;
    logic ext;
    logic swing;
    logic edge_pos;
    logic ddr;
    logic cal_long;
    logic des;
    logic des_q;
    logic fsr;
    logic sclk;
    logic sio;
    logic scs_n;
    logic [1:0] ph;
    logic output_data_clock;
    logic launch;
  } cmsd_core_t;

endpackage : cmsd_pkg

//--- cmsd_strap_if.sv
// strap comparator samples and classified levels between sense and decode
`timescale 1ns/1ps
interface cmsd_strap_if;
  import cmsd_pkg::*;
  logic [STRAP_N-1:0] above_hi;
  logic [STRAP_N-1:0] below_lo;
  cmsd_level_t [STRAP_N-1:0] level;
  modport sense (input above_hi, input below_lo, output level);
  modport decode (output above_hi, output below_lo, input level);
endinterface : cmsd_strap_if

//--- cmsd_strap_model.sv
// strap wiring model: three-level pins seen through the two comparators
`timescale 1ns/1ps
module cmsd_strap_model import cmsd_pkg::*; (
  // clock
  input wire logic clk,
  // wanted pin levels, two bits per strap
  input wire logic [2*STRAP_N-1:0] lv,
  // comparators
  output logic [STRAP_N-1:0] above_hi,
  output logic [STRAP_N-1:0] below_lo
);
  // ==========================================================
  // comparators
  // registered so pin changes land just after an edge, like a real host
  always_ff @(posedge clk) begin
    for (int i = 0; i < STRAP_N; i++) begin
      above_hi[i] <= (lv[2*i+:2] == LVL_HIGH);
      below_lo[i] <= (lv[2*i+:2] == LVL_LOW);
    end
  end
endmodule : cmsd_strap_model

//--- cmsd_strap_sense.sv
// three-level strap classifier with a short stability filter
`timescale 1ns/1ps
module cmsd_strap_sense import cmsd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // straps
  cmsd_strap_if.sense sif
);

  // ==========================================================
  // raw classification
  cmsd_level_t [STRAP_N-1:0] raw;
  cmsd_sense_t s_q;
  cmsd_sense_t s_d;

  // neither comparator tripped means nobody drives the pin
  for (genvar i = 0; i < STRAP_N; i++) begin : g_raw
    assign raw[i] = sif.above_hi[i] ? LVL_HIGH : (sif.below_lo[i] ? LVL_LOW : LVL_FLOAT);
  end

  // ==========================================================
  // stability filter, runs all the time so no write is needed
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < STRAP_N; i++) begin
      if (raw[i] != s_q.cand[i]) begin
        s_d.cand[i] = raw[i];
        s_d.cnt[i] = 2'h0;
      end else if (s_q.cnt[i] != STABLE_LAST) begin
        s_d.cnt[i] = s_q.cnt[i] + 2'h1;
      end else begin
        s_d.stable[i] = s_q.cand[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < STRAP_N; i++) begin
        s_q.cand[i] <= LVL_FLOAT;
        s_q.cnt[i] <= 2'h0;
        s_q.stable[i] <= LVL_FLOAT;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.level = s_q.stable;

endmodule : cmsd_strap_sense

//--- cmsd_top.sv
// control mode strap decoder: mode select, pin settings, serial pin reuse
`timescale 1ns/1ps
module cmsd_top import cmsd_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // strap comparators, one bit per strap
  input wire logic [STRAP_N-1:0] STRAP_ABOVE_HI,
  input wire logic [STRAP_N-1:0] STRAP_BELOW_LO,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // mode and function settings
  output logic EXT_MODE,
  output logic FULL_SCALE_NORMAL,
  output logic OUTPUT_SWING_LEVEL,
  output logic OUTPUT_LAUNCH_EDGE_SELECT,
  output logic DDR_EN,
  output logic CALIBRATION_DELAY_SELECT,
  output logic DES_EN,
  output logic DES_SRC_Q,
  output logic OTHER_PAIR_OFF,
  // serial interface taken from the straps
  output logic SERIAL_CLOCK,
  output logic SERIAL_IO_LINE,
  output logic SERIAL_CHIP_SELECT_N,
  // output data clock
  output logic OUTPUT_DATA_CLOCK,
  output logic WORD_LAUNCH
);

  // ==========================================================
  // strap sensing
  cmsd_strap_if sif ();

  assign sif.above_hi = STRAP_ABOVE_HI;
  assign sif.below_lo = STRAP_BELOW_LO;

  cmsd_strap_sense u_sense (
    .clk (CLK),
    .rst (RST),
    .sif (sif)
  );

  cmsd_level_t lv_prim;
  cmsd_level_t lv_sec;
  cmsd_level_t lv_range;
  cmsd_level_t lv_swing;
  cmsd_level_t lv_edge;
  cmsd_level_t lv_cal;

  assign lv_prim = sif.level[ST_PRIM];
  assign lv_sec = sif.level[ST_SEC];
  assign lv_range = sif.level[ST_RANGE];
  assign lv_swing = sif.level[ST_SWING];
  assign lv_edge = sif.level[ST_EDGE];
  assign lv_cal = sif.level[ST_CALIBRATION_DELAY_SELECT];

  // ==========================================================
  // mode decode
  logic sec_ok;
  logic ext_d;

  assign sec_ok = (lv_sec != LVL_LOW);
  // a high primary strap always wins; a low secondary keeps pins in charge
  assign ext_d = sec_ok && (lv_prim != LVL_HIGH) &&
                 ((lv_prim == LVL_LOW) || (lv_range == LVL_FLOAT));

  // ==========================================================
  // next state
  cmsd_core_t c_q;
  cmsd_core_t c_d;
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    for (int i = 0; i < STRAP_N; i++) begin
      status[2*i +: 2] = sif.level[i];
    end
    status[STAT_EXT] = c_q.ext;
    status[STAT_DES] = c_q.des;
    status[STAT_DDR] = c_q.ddr;
  end

  always_comb begin
    c_d = c_q;
    c_d.ext = ext_d;

    // register port, never stalls
    if (REG_WR && (REG_ADDR == OFS_CFG)) begin
      c_d.cfg = REG_WDATA[CFG_W-1:0];
    end
    c_d.rdata = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        OFS_CFG: c_d.rdata = {{(32-CFG_W){1'b0}}, c_q.cfg};
        OFS_STATUS: c_d.rdata = status;
        default: c_d.rdata = 32'h0000_0000;
      endcase
    end

    if (ext_d) begin
      // settings come from software while the pins carry the serial port
      c_d.swing = c_q.cfg[CFG_SWING];
      c_d.edge_pos = c_q.cfg[CFG_EDGE];
      c_d.ddr = c_q.cfg[CFG_DDR];
      c_d.des = c_q.cfg[CFG_DES];
      c_d.des_q = c_q.cfg[CFG_DESQ] & c_q.cfg[CFG_DES];
      c_d.cal_long = c_q.cfg[CFG_CAL] & ~c_q.cfg[CFG_DES];
      c_d.fsr = c_q.cfg[CFG_FSR];
      c_d.sclk = STRAP_ABOVE_HI[ST_SWING];
      c_d.sio = STRAP_ABOVE_HI[ST_EDGE];
      c_d.scs_n = ~STRAP_BELOW_LO[ST_CALIBRATION_DELAY_SELECT];
    end else begin
      c_d.fsr = (lv_range == LVL_HIGH);
      // floating swing strap has no meaning here; treated as normal
      c_d.swing = (lv_swing != LVL_LOW);
      c_d.ddr = (lv_edge == LVL_FLOAT);
      c_d.edge_pos = (lv_edge == LVL_HIGH);
      c_d.cal_long = (lv_cal == LVL_HIGH);
      c_d.des = (lv_cal == LVL_FLOAT);
      c_d.des_q = 1'b0;
      c_d.sclk = 1'b0;
      c_d.sio = 1'b0;
      c_d.scs_n = 1'b1;
    end

    // quarter-rate clock in double-rate mode, half rate otherwise
    if (c_d.ddr) begin
      c_d.ph = c_q.ph + PH_STEP;
      c_d.output_data_clock = c_d.ph[1];
    end else begin
      c_d.ph = PH_RST;
      c_d.output_data_clock = ~c_q.output_data_clock;
    end
    // one word per clock edge in double-rate, else only on the chosen edge
    c_d.launch = (c_d.output_data_clock != c_q.output_data_clock) && (c_d.ddr || (c_d.output_data_clock == c_d.edge_pos));
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      c_q.cfg <= CFG_RST[CFG_W-1:0];
      c_q.rdata <= 32'h0000_0000;
      c_q.ext <= 1'b0;
      c_q.swing <= 1'b1;
      c_q.edge_pos <= 1'b1;
      c_q.ddr <= 1'b0;
      c_q.cal_long <= 1'b0;
      c_q.des <= 1'b0;
      c_q.des_q <= 1'b0;
      c_q.fsr <= 1'b1;
      c_q.sclk <= 1'b0;
      c_q.sio <= 1'b0;
      c_q.scs_n <= 1'b1;
      c_q.ph <= PH_RST;
      c_q.output_data_clock <= 1'b0;
      c_q.launch <= 1'b0;
    end else begin
      c_q <= c_d;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA = c_q.rdata;
  assign EXT_MODE = c_q.ext;
  assign FULL_SCALE_NORMAL = c_q.fsr;
  assign OUTPUT_SWING_LEVEL = c_q.swing;
  assign OUTPUT_LAUNCH_EDGE_SELECT = c_q.edge_pos;
  assign DDR_EN = c_q.ddr;
  assign CALIBRATION_DELAY_SELECT = c_q.cal_long;
  assign DES_EN = c_q.des;
  assign DES_SRC_Q = c_q.des_q;
  assign OTHER_PAIR_OFF = c_q.des;
  assign SERIAL_CLOCK = c_q.sclk;
  assign SERIAL_IO_LINE = c_q.sio;
  assign SERIAL_CHIP_SELECT_N = c_q.scs_n;
  assign OUTPUT_DATA_CLOCK = c_q.output_data_clock;
  assign WORD_LAUNCH = c_q.launch;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  prim_high_pin_a: assert property (lv_prim == LVL_HIGH |=> !EXT_MODE && SERIAL_CHIP_SELECT_N)
    else $error("primary high did not give pin mode");

  range_picks_a: assert property ((lv_prim == LVL_FLOAT) && sec_ok |=> EXT_MODE == $past(lv_range == LVL_FLOAT))
    else $error("range strap did not pick the mode");

  fsr_pin_a: assert property (!ext_d && (lv_range != LVL_FLOAT) |=> FULL_SCALE_NORMAL == $past(lv_range == LVL_HIGH))
    else $error("full scale range wrong in pin mode");

  ext_enter_a: assert property (sec_ok && (lv_prim == LVL_LOW) |=> EXT_MODE)
    else $error("extended mode not entered");

  swing_pin_a: assert property (!ext_d && (lv_swing != LVL_FLOAT) |=> OUTPUT_SWING_LEVEL == $past(lv_swing == LVL_HIGH))
    else $error("output swing wrong in pin mode");

  edge_pin_a: assert property (!ext_d && (lv_edge != LVL_FLOAT) |=> !DDR_EN && OUTPUT_LAUNCH_EDGE_SELECT == $past(lv_edge == LVL_HIGH))
    else $error("launch edge wrong in pin mode");

  ddr_pin_a: assert property (!ext_d && (lv_edge == LVL_FLOAT) |=> DDR_EN)
    else $error("floating edge strap did not give double rate");

  cal_pin_a: assert property (!ext_d && (lv_cal != LVL_FLOAT) |=> !DES_EN && CALIBRATION_DELAY_SELECT == $past(lv_cal == LVL_HIGH))
    else $error("calibration delay wrong in pin mode");

  des_pin_a: assert property (!ext_d && (lv_cal == LVL_FLOAT) |=> DES_EN && !DES_SRC_Q && !CALIBRATION_DELAY_SELECT)
    else $error("floating delay strap did not give short delay and dual edge");

  serial_route_a: assert property (ext_d |=> SERIAL_CLOCK == $past(STRAP_ABOVE_HI[ST_SWING]) && SERIAL_IO_LINE == $past(STRAP_ABOVE_HI[ST_EDGE]))
    else $error("serial pins not routed");

  serial_idle_a: assert property (!ext_d |=> !SERIAL_CLOCK && SERIAL_CHIP_SELECT_N)
    else $error("serial pins not idle in pin mode");

  des_route_a: assert property ((DES_EN || DES_SRC_Q) |-> OTHER_PAIR_OFF && DES_EN)
    else $error("other pair left on in dual edge");

  ddr_quarter_a: assert property (DDR_EN && $rose(OUTPUT_DATA_CLOCK) ##1 DDR_EN[*3] |-> $past(OUTPUT_DATA_CLOCK, 2) && !$past(OUTPUT_DATA_CLOCK) && !OUTPUT_DATA_CLOCK)
    else $error("double rate clock not at quarter rate");

  ddr_word_a: assert property (DDR_EN && $past(DDR_EN) && $changed(OUTPUT_DATA_CLOCK) |-> WORD_LAUNCH)
    else $error("no word on a double rate clock edge");

  status_read_a: assert property (REG_RD && (REG_ADDR == OFS_STATUS) |=> REG_RDATA[STAT_EXT] == $past(EXT_MODE))
    else $error("status read does not show mode");

endmodule : cmsd_top

//--- tb.sv
// self-checking bench for the control mode strap decoder
`timescale 1ns/1ps
module tb;
  import cmsd_pkg::*;
  localparam logic [1:0] lo = LVL_LOW;
  localparam logic [1:0] hi = LVL_HIGH;
  localparam logic [1:0] fl = LVL_FLOAT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2*STRAP_N-1:0] lv = 12'hAAA;
  logic [STRAP_N-1:0] ahi, blo;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata, d;
  logic ext, fsr, swing, edg, ddr, cal, des, desq, off, sclk, sio, scs_n, output_data_clock, launch;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  // ==========================================================
  // design and strap wiring
  cmsd_strap_model u_straps (.clk(clk), .lv(lv), .above_hi(ahi), .below_lo(blo));
  cmsd_top u_dut (.CLK(clk), .RST(rst), .STRAP_ABOVE_HI(ahi), .STRAP_BELOW_LO(blo),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .EXT_MODE(ext), .FULL_SCALE_NORMAL(fsr), .OUTPUT_SWING_LEVEL(swing),
    .OUTPUT_LAUNCH_EDGE_SELECT(edg), .DDR_EN(ddr), .CALIBRATION_DELAY_SELECT(cal),
    .DES_EN(des), .DES_SRC_Q(desq), .OTHER_PAIR_OFF(off), .SERIAL_CLOCK(sclk),
    .SERIAL_IO_LINE(sio), .SERIAL_CHIP_SELECT_N(scs_n), .OUTPUT_DATA_CLOCK(output_data_clock),
    .WORD_LAUNCH(launch));

  always #2.5 clk = ~clk;

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // settle covers model edge, five-sample filter and decode register
  task automatic setlv(input logic [1:0] p, s, r, w, e, c);
    @(posedge clk);
    lv <= {c, e, w, r, s, p};
    repeat (10) @(posedge clk);
    #1;
  endtask : setlv

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : reg_rd

  task automatic clk_chk(input int tog, input int lau);
    int nt;
    int nl;
    logic last;
    nt = 0;
    nl = 0;
    last = output_data_clock;
    repeat (8) begin
      @(posedge clk);
      #1;
      if (output_data_clock !== last) nt++;
      if (launch === 1'b1) nl++;
      last = output_data_clock;
    end
    chk(nt, tog);
    chk(nl, lau);
  endtask : clk_chk

  // ==========================================================
  // scenarios
  // called at the release edge, so the reset values still stand
  task automatic t_reset;
    #1;
    chk(ext, 1'b0);
    chk(scs_n, 1'b1);
    // straps all read floating after reset, which decodes to extended mode
    @(posedge clk);
    #1;
    chk(ext, 1'b1);
    chk(scs_n, 1'b1);
    reg_rd(OFS_CFG, d);
    chk(d, CFG_RST);
  endtask : t_reset

  task automatic t_pin;
    for (int i = 0; i < 3; i++) begin
      setlv(hi, fl, i ? hi : lo, i ? hi : lo, 2'(i), 2'(i));
      chk(ext, 1'b0);
      chk(sclk, 1'b0);
      chk(scs_n, 1'b1);
      chk(fsr, i > 0);
      chk(swing, i > 0);
      if (i < 2) chk(edg, i);
      chk(ddr, i == 2);
      chk(cal, i == 1);
      chk(des, i == 2);
      chk(off, i == 2);
      chk(desq, 1'b0);
      clk_chk(i == 2 ? 4 : 8, 4);
    end
  endtask : t_pin

  task automatic t_mode;
    setlv(fl, hi, hi, hi, hi, hi);
    chk(ext, 1'b0);
    setlv(fl, fl, lo, hi, hi, hi);
    chk(ext, 1'b0);
    chk(fsr, 1'b0);
    setlv(fl, hi, fl, hi, hi, hi);
    chk(ext, 1'b1);
    setlv(lo, fl, hi, hi, hi, hi);
    chk(ext, 1'b1);
    // a low secondary strap keeps the pins in charge
    setlv(lo, lo, fl, hi, hi, hi);
    chk(ext, 1'b0);
  endtask : t_mode

  task automatic t_serial;
    setlv(lo, fl, hi, hi, hi, lo);
    chk(sclk, 1'b1);
    chk(sio, 1'b1);
    chk(scs_n, 1'b0);
    setlv(lo, fl, hi, lo, lo, hi);
    chk(sclk, 1'b0);
    chk(sio, 1'b0);
    chk(scs_n, 1'b1);
  endtask : t_serial

  // extended mode: settings come from the config word
  task automatic t_regs;
    reg_wr(OFS_CFG, 32'hFFFF_FF3C);
    reg_rd(OFS_CFG, d);
    chk(d, 32'h0000_003C);
    chk(ddr, 1'b1);
    chk(des, 1'b1);
    chk(desq, 1'b1);
    chk(cal, 1'b0);
    chk(fsr, 1'b0);
    chk(swing, 1'b0);
    chk(edg, 1'b0);
    reg_wr(OFS_STATUS, 32'h0);
    reg_rd(OFS_STATUS, d);
    chk(d, {17'h0, 3'h7, lv});
    reg_rd(8'h08, d);
    chk(d, 32'h0);
    clk_chk(4, 4);
    // long delay only holds while dual edge is off
    reg_wr(OFS_CFG, 32'h0000_004B);
    reg_rd(OFS_CFG, d);
    chk(d, 32'h0000_004B);
    chk(swing, 1'b1);
    chk(edg, 1'b1);
    chk(ddr, 1'b0);
    chk(cal, 1'b1);
    chk(des, 1'b0);
    chk(off, 1'b0);
    chk(fsr, 1'b1);
    clk_chk(8, 4);
  endtask : t_regs

  // a three-cycle dip must not reach the range setting
  task automatic t_glitch;
    setlv(hi, fl, hi, hi, hi, lo);
    @(posedge clk);
    lv[5:4] <= lo;
    repeat (3) @(posedge clk);
    lv[5:4] <= hi;
    repeat (12) begin
      @(posedge clk);
      #1;
      chk(fsr, 1'b1);
    end
  endtask : t_glitch

  // ==========================================================
  // run control
  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      final_report;
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_pin;
    t_mode;
    t_serial;
    t_regs;
    t_glitch;
    final_report;
  end
endmodule : tb
